// ==== bench/isf_host.sv ====
module isf_host
   import isf_pkg::*;
(
   // Clock and answer
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   // Requests
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic cmd_wr,
   output logic [7:0] cmd
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      cmd_wr = 1'b0;
      cmd = 8'h00;
   end

   // Released lines show the inverse, never a stale copy of the request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      reg_rd = 1'b1;
      addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      addr = ~a;
      while (rvalid !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      d = rdata;
   endtask

   // Access request must precede setting the read enable bit
   task automatic grant();
      @(posedge clk);
      #1;
      cmd_wr = 1'b1;
      cmd = CMD_ACCESS;
      @(posedge clk);
      #1;
      cmd_wr = 1'b0;
      cmd = ~CMD_ACCESS;
   endtask
endmodule

// ==== bench/tb.sv ====
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module tb
   import isf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic acc_en = 1'b0;
   logic gyr_en = 1'b0;
   logic mag_en = 1'b0;
   logic smp_valid = 1'b0;
   logic [SENSOR_W-1:0] smp_acc = '0;
   logic [SENSOR_W-1:0] smp_gyr = '0;
   logic [SENSOR_W-1:0] smp_mag = '0;
   logic reg_wr, reg_rd, cmd_wr, rvalid, irq;
   logic [7:0] reg_addr, reg_wdata, rdata, cmd, b;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   // Config written beside config read back; bit 6 always reads 0
   logic [15:0] rows [6] = '{16'hffbf, 16'h0101, 16'h0606, 16'h9a9a, 16'he2a2, 16'h4c0c};

   isf_fifo u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
      .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
      .I_CMD_WR(cmd_wr), .I_CMD(cmd), .I_ACC_EN(acc_en), .I_GYR_EN(gyr_en), .I_MAG_EN(mag_en),
      .I_SMP_VALID(smp_valid), .I_SMP_ACC(smp_acc), .I_SMP_GYR(smp_gyr), .I_SMP_MAG(smp_mag),
      .O_SECOND_INTERRUPT_OUT(irq));

   isf_host u_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .addr(reg_addr), .wdata(reg_wdata), .cmd_wr(cmd_wr), .cmd(cmd));

   always #5 clk = ~clk;

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   // Byte k of sensor s in sample n; sample number modulo 4 sits in the top two bits
   function automatic logic [7:0] bv(int n, int s, int k);
      return 8'(n * 64 + s * 16 + k + 1);
   endfunction

   function automatic logic [SENSOR_W-1:0] sv(int n, int s);
      logic [SENSOR_W-1:0] r;
      for (int k = 0; k < SENSOR_BYTES; k++)
         r[8*k+:8] = bv(n, s, k);
      return r;
   endfunction

   // One strobe feeds all sensors, so they share one rate; gap leaves room for a burst
   task automatic push(int n);
      @(posedge clk);
      #1;
      smp_acc = sv(n, 0);
      smp_gyr = sv(n, 1);
      smp_mag = sv(n, 2);
      smp_valid = 1'b1;
      @(posedge clk);
      #1;
      smp_valid = 1'b0;
      smp_acc = ~smp_acc;
      smp_gyr = ~smp_gyr;
      smp_mag = ~smp_mag;
      repeat (20) @(posedge clk);
   endtask

   task automatic chk_rd(logic [7:0] a, logic [7:0] e);
      u_host.rd(a, b);
      `CHK(rvalid, 1'b1)
      `CHK(b, e)
   endtask

   // Whole sample in 6, 12 or 18 byte units
   task automatic drain(int n, int k);
      for (int j = 0; j < SENSOR_BYTES * k; j++)
         chk_rd(ADDR_DATA, bv(n, j / 6, j % 6));
   endtask

   task automatic open_cfg(logic [7:0] d);
      u_host.wr(ADDR_CFG, CFG_RESET);
      u_host.grant();
      u_host.wr(ADDR_CFG, d);
   endtask

   task automatic finish_test();
      $display("Mismatches %0d, compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         u_host.wr(ADDR_CFG, rows[i][15:8]);
         chk_rd(ADDR_CFG, rows[i][7:0]);
      end
      u_host.wr(ADDR_CFG, CFG_RESET);
      // Reset values, unmapped address, read-only status
      chk_rd(ADDR_CFG, CFG_RESET);
      chk_rd(8'h40, ZERO_BYTE);
      u_host.wr(ADDR_STAT, 8'hff);
      chk_rd(ADDR_STAT, 8'h00);
      `CHK(irq, 1'b0)
      // Read enable set without the access command gives nothing
      acc_en = 1'b1;
      u_host.wr(ADDR_CFG, 8'h81);
      push(0);
      chk_rd(ADDR_DATA, ZERO_BYTE);
      for (int k = 1; k <= 3; k++)
      begin
         gyr_en = (k > 1);
         mag_en = (k > 2);
         open_cfg(8'h81);
         push(k);
         push(k + 8);
         drain(k, k);
         drain(k + 8, k);
         chk_rd(ADDR_DATA, ZERO_BYTE);
         `CHK(irq, 1'b0)
      end
      // Watermark at a quarter of 16 samples, then fill-once overflow
      gyr_en = 1'b0;
      mag_en = 1'b0;
      open_cfg(8'h91);
      for (int i = 0; i < 3; i++)
         push(i);
      `CHK(irq, 1'b0)
      push(3);
      `CHK(irq, 1'b1)
      chk_rd(ADDR_STAT, 8'h54);
      for (int i = 4; i < 17; i++)
         push(i);
      chk_rd(ADDR_STAT, 8'h7f);
      chk_rd(ADDR_STAT, 8'h5f);
      drain(0, 1);
      // Streaming keeps the newest samples
      open_cfg(8'h82);
      for (int i = 0; i < 17; i++)
         push(i);
      drain(1, 1);
      // Reset in mid-run empties the store and restores the register defaults
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      `CHK(rvalid, 1'b0)
      `CHK(irq, 1'b0)
      chk_rd(ADDR_CFG, CFG_RESET);
      chk_rd(ADDR_STAT, ZERO_BYTE);
      // Magnetometer alone leaves the buffer idle
      acc_en = 1'b0;
      mag_en = 1'b1;
      open_cfg(8'h81);
      push(0);
      chk_rd(ADDR_STAT, 8'h00);
      finish_test();
   end
endmodule

// ==== rtl/isf_fifo.sv ====
// Contract
// - Provide a 1536-byte first-in first-out store for sensor samples.
// - Each data register read removes the returned byte permanently.
// - Three modes via two-bit field: bypass, fill-once, streaming.
// - Buffer is active only with accelerometer or gyroscope enabled.
// - Second interrupt output asserts when fill reaches enabled watermark.
// - Config bit 7 gates data register reads; resets to zero.
// - Bits 5:4 pick watermark at quarter, half or three quarters.
// - Bits 3:2 pick 16/32/64/128 samples per sensor; with three sensors at 128 the code clamps capacity to 1536 bytes.
// - Single sensor order: X low, X high, Y low, Y high, Z low, Z high.
// - Three sensors append six magnetometer bytes after accel and gyro.
// - Mode codes: 00 bypass, 01 fill-once, 10 streaming, 11 unused.
// - Status: bit6 watermark, bit5 overflow, bit4 not empty, 3:0 level.
// - Buffered bytes come out one at a time from register 0x14.
module isf_fifo
   import isf_pkg::*;
(
   // Clock, reset, enable
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   // Register port
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   output logic [7:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   // Command register
   input wire logic I_CMD_WR,
   input wire logic [7:0] I_CMD,
   // Sensor side
   input wire logic I_ACC_EN,
   input wire logic I_GYR_EN,
   input wire logic I_MAG_EN,
   input wire logic I_SMP_VALID,
   input wire logic [SENSOR_W-1:0] I_SMP_ACC,
   input wire logic [SENSOR_W-1:0] I_SMP_GYR,
   input wire logic [SENSOR_W-1:0] I_SMP_MAG,
   // Interrupt
   output logic O_SECOND_INTERRUPT_OUT
);
   logic [7:0] cfg;
   logic granted;
   isf_mode_t mode;
   logic [1:0] wtm_sel, size_sel;
   logic rd_mode, active;
   logic [4:0] bps;
   logic [7:0] cap_samp, wm_samp, fss;
   logic [CW-1:0] cap_bytes, cap_full, count;
   logic [7:0] samp;
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [4:0] rd_byte;
   isf_wstate_t wstate;
   logic [SAMPLE_W-1:0] pack, lat;
   logic [4:0] lat_bps, widx;
   logic room, commit, drop, pop, last_byte, wm_hit, overflow;
   logic [7:0] mem_rdata;
   logic rd_p1, pop1;
   logic [7:0] addr1, stat1;

   function automatic logic [AW-1:0] ring_add(input logic [AW-1:0] p, input logic [CW-1:0] inc);
      logic [AW:0] s;
      s = {1'b0, p} + inc;
      if (s >= (AW+1)'(DEPTH))
      begin
         s = s - (AW+1)'(DEPTH);
      end
      return s[AW-1:0];
   endfunction

   assign mode = isf_mode_t'(cfg[CFG_MODE_LSB +: 2]);
   assign wtm_sel = cfg[CFG_WTM_LSB +: 2];
   assign size_sel = cfg[CFG_SIZE_LSB +: 2];
   assign rd_mode = cfg[CFG_RD_BIT];
   assign active = (mode == MODE_FIFO || mode == MODE_STREAM) && (I_ACC_EN || I_GYR_EN);
   assign bps = 5'(({1'b0, I_ACC_EN} + {1'b0, I_GYR_EN} + {1'b0, I_MAG_EN}) * SENSOR_BYTES);
   assign cap_samp = 8'(BASE_SAMPLES) << size_sel;
   assign cap_full = CW'(cap_samp) * CW'(bps);
   // Three sensors at 128 samples exceed storage, so capacity clamps to the memory
   assign cap_bytes = (cap_full > CW'(DEPTH)) ? CW'(DEPTH) : cap_full;
   assign wm_samp = (cap_samp >> 2) * {6'b0, wtm_sel};
   assign wm_hit = (wtm_sel != 2'b00) && (samp >= wm_samp);
   assign fss = ((samp >> size_sel) > FSS_MAX) ? FSS_MAX : (samp >> size_sel);
   assign room = (count + CW'(lat_bps)) <= cap_bytes;
   assign commit = (wstate == WS_COMMIT);
   assign drop = commit && !room;
   assign pop = I_CE && I_REG_RD && (I_REG_ADDR == ADDR_DATA) && rd_mode && granted && (count != '0);
   assign last_byte = (rd_byte == bps - 5'd1);

   // Enabled sensors packed accel, gyro, mag, low byte first
   always_comb
   begin
      int pos;
      pos = 0;
      pack = '0;
      if (I_ACC_EN)
      begin
         pack[pos +: SENSOR_W] = I_SMP_ACC;
         pos = pos + SENSOR_W;
      end
      if (I_GYR_EN)
      begin
         pack[pos +: SENSOR_W] = I_SMP_GYR;
         pos = pos + SENSOR_W;
      end
      if (I_MAG_EN)
      begin
         pack[pos +: SENSOR_W] = I_SMP_MAG;
      end
   end

   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         cfg <= CFG_RESET;
      end
      else if (I_CE && I_REG_WR && I_REG_ADDR == ADDR_CFG)
      begin
         cfg <= I_REG_WDATA & CFG_WMASK;
      end
   end

   // Access lasts from the command until software drops the read enable
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         granted <= 1'b0;
      end
      else if (I_CE)
      begin
         if (I_CMD_WR && I_CMD == CMD_ACCESS)
         begin
            granted <= 1'b1;
         end
         else if (I_REG_WR && I_REG_ADDR == ADDR_CFG && !I_REG_WDATA[CFG_RD_BIT])
         begin
            granted <= 1'b0;
         end
      end
   end

   // Sample writer: bytes land beyond the committed region (over the oldest sample when streaming with cap_bytes at 1536) and become visible only at commit
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         wstate <= WS_IDLE;
         lat <= '0;
         lat_bps <= '0;
         widx <= '0;
      end
      else if (I_CE)
      begin
         case (wstate)
            WS_IDLE:
            begin
               if (!active)
               begin
                  wstate <= WS_IDLE;
               end
               else if (I_SMP_VALID && (mode == MODE_STREAM || (count + CW'(bps)) <= cap_bytes))
               begin
                  lat <= pack;
                  lat_bps <= bps;
                  widx <= '0;
                  wstate <= WS_WRITE;
               end
            end
            WS_WRITE:
            begin
               lat <= lat >> 8;
               widx <= widx + 5'd1;
               if (!active)
               begin
                  wstate <= WS_IDLE;
               end
               else if (widx == lat_bps - 5'd1)
               begin
                  wstate <= WS_COMMIT;
               end
            end
            WS_COMMIT:
            begin
               wstate <= WS_IDLE;
            end
            default:
            begin
               wstate <= WS_IDLE;
            end
         endcase
      end
   end

   // Levels and pointers; bypass or idle sensors flush the store
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         count <= '0;
         samp <= '0;
         wr_ptr <= '0;
         rd_ptr <= '0;
         rd_byte <= '0;
      end
      else if (I_CE)
      begin
         if (!active)
         begin
            count <= '0;
            samp <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            rd_byte <= '0;
         end
         else
         begin
            count <= count + (commit ? CW'(lat_bps) : '0) - (drop ? CW'(lat_bps) : '0) - CW'(pop);
            samp <= samp + 8'(commit) - 8'(drop) - 8'(pop && last_byte && !drop);
            if (commit)
            begin
               wr_ptr <= ring_add(wr_ptr, CW'(lat_bps));
            end
            rd_ptr <= ring_add(rd_ptr, (drop ? CW'(lat_bps) : '0) + CW'(pop));
            if (drop || (pop && last_byte))
            begin
               rd_byte <= '0;
            end
            else if (pop)
            begin
               rd_byte <= rd_byte + 5'd1;
            end
         end
      end
   end

   // Overflow is sticky until a status read; a new overflow wins over that read
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         overflow <= 1'b0;
      end
      else if (I_CE)
      begin
         if (wstate == WS_IDLE && active && I_SMP_VALID && mode == MODE_FIFO
             && (count + CW'(bps)) > cap_bytes)
         begin
            overflow <= 1'b1;
         end
         else if (I_REG_RD && I_REG_ADDR == ADDR_STAT)
         begin
            overflow <= 1'b0;
         end
      end
   end

   isf_mem u_mem (
      .clk(I_CORE_CLK),
      .ce(I_CE),
      .we(wstate == WS_WRITE),
      .waddr(ring_add(wr_ptr, CW'(widx))),
      .wdata(lat[7:0]),
      .re(pop),
      .raddr(rd_ptr),
      .rdata(mem_rdata)
   );

   // Two-stage read answer: memory register, then output register
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         rd_p1 <= 1'b0;
         pop1 <= 1'b0;
         addr1 <= '0;
         stat1 <= '0;
         O_REG_RDATA <= '0;
         O_REG_RVALID <= 1'b0;
         O_SECOND_INTERRUPT_OUT <= 1'b0;
      end
      else if (I_CE)
      begin
         rd_p1 <= I_REG_RD;
         pop1 <= pop;
         addr1 <= I_REG_ADDR;
         stat1 <= {1'b0, wm_hit, overflow, count != '0, fss[3:0]};
         O_REG_RVALID <= rd_p1;
         O_SECOND_INTERRUPT_OUT <= wm_hit;
         case (addr1)
            ADDR_CFG: O_REG_RDATA <= cfg;
            ADDR_DATA: O_REG_RDATA <= pop1 ? mem_rdata : ZERO_BYTE;
            ADDR_STAT: O_REG_RDATA <= stat1;
            default: O_REG_RDATA <= ZERO_BYTE;
         endcase
      end
   end

   property p_cap;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) count <= CW'(DEPTH) && count <= cap_bytes + CW'(bps);
   endproperty
   a_cap: assert property (p_cap) else $error("fill beyond capacity");

   property p_pop;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) pop && !commit && active |=> count == $past(count) - 12'h001;
   endproperty
   a_pop: assert property (p_pop) else $error("read did not remove byte");

   property p_gate;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) (!rd_mode || !granted) |-> !pop;
   endproperty
   a_gate: assert property (p_gate) else $error("read while disabled");

   property p_bypass;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) I_CE && mode == MODE_BYPASS |=> count == '0 && samp == '0;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass kept data");

   property p_int;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) I_CE |=> O_SECOND_INTERRUPT_OUT == $past(wm_hit);
   endproperty
   a_int: assert property (p_int) else $error("interrupt not tied to watermark");

   property p_wtm_half;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) wtm_sel == 2'b10 && samp >= (cap_samp >> 1) |-> wm_hit;
   endproperty
   a_wtm_half: assert property (p_wtm_half) else $error("half watermark missed");

   property p_ovf;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N)
         I_CE && wstate == WS_IDLE && active && I_SMP_VALID && mode == MODE_FIFO
         && count + CW'(bps) > cap_bytes |=> overflow && wstate == WS_IDLE;
   endproperty
   a_ovf: assert property (p_ovf) else $error("full fill-once buffer accepted sample");

   property p_atomic;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) !commit |=> count <= $past(count);
   endproperty
   a_atomic: assert property (p_atomic) else $error("level grew outside commit");

   property p_order;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N)
         I_CE && wstate == WS_IDLE && active && I_SMP_VALID && I_ACC_EN
         && (mode == MODE_STREAM || count + CW'(bps) <= cap_bytes) |=> lat[7:0] == $past(I_SMP_ACC[7:0]);
   endproperty
   a_order: assert property (p_order) else $error("first byte not accel X low");

   property p_three;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) I_ACC_EN && I_GYR_EN && I_MAG_EN |-> bps == 5'd18;
   endproperty
   a_three: assert property (p_three) else $error("three-sensor sample not 18 bytes");

   property p_status;
      @(posedge I_CORE_CLK) disable iff (!I_RST_N) I_CE && rd_p1 && addr1 == ADDR_STAT |=> O_REG_RVALID && O_REG_RDATA[4] == $past(stat1[4]);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

   c_drain: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) pop ##1 count == '0);
   c_drop: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) drop);
   c_ovf: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) $rose(overflow));
   c_wtm: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) $rose(O_SECOND_INTERRUPT_OUT));
endmodule

// ==== rtl/isf_mem.sv ====
module isf_mem
   import isf_pkg::*;
#(
   parameter int W = 8,
   parameter int D = DEPTH,
   parameter int A = AW
)
(
   // Clock
   input wire logic clk,
   input wire logic ce,
   // Write side
   input wire logic we,
   input wire logic [A-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Read side, data registered
   input wire logic re,
   input wire logic [A-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [D];

   always_ff @(posedge clk)
   begin
      if (ce && we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (ce && re)
      begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ==== rtl/isf_pkg.sv ====
package isf_pkg;
   // Storage geometry
   localparam int DEPTH = 1536;
   localparam int AW = 11;
   localparam int CW = 12;
   // Register map and command
   localparam logic [7:0] ADDR_CFG = 8'h13;
   localparam logic [7:0] ADDR_DATA = 8'h14;
   localparam logic [7:0] ADDR_STAT = 8'h15;
   localparam logic [7:0] CMD_ACCESS = 8'h0d;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_WMASK = 8'hbf;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Field positions
   localparam int CFG_RD_BIT = 7;
   localparam int CFG_WTM_LSB = 4;
   localparam int CFG_SIZE_LSB = 2;
   localparam int CFG_MODE_LSB = 0;
   // Sample layout
   localparam int SENSOR_BYTES = 6;
   localparam int SENSOR_W = 48;
   localparam int SAMPLE_W = 144;
   localparam int BASE_SAMPLES = 16;
   localparam logic [7:0] FSS_MAX = 8'h0f;
   typedef enum logic [1:0] {
      MODE_BYPASS = 2'b00,
      MODE_FIFO = 2'b01,
      MODE_STREAM = 2'b10,
      MODE_UNUSED = 2'b11
   } isf_mode_t;
   typedef enum logic [2:0] {
      WS_IDLE = 3'b001,
      WS_WRITE = 3'b010,
      WS_COMMIT = 3'b100
   } isf_wstate_t;
endpackage
